// [rtl/pdsf_pkg.sv]
// Package: shared constants, types and the noise table for the pixel dither and span filter
package pdsf_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int CHAN_W  = 8;             // Colour channel width
  localparam int NOISE_W = 7;             // Noise table entry width
  localparam int WIDE_W  = 9;             // Intermediate arithmetic width
  localparam int QOUT_W  = 6;             // Widest dithered output
  localparam int COORD_W = 12;            // Pixel coordinate width
  localparam int TILE_W  = 5;             // Log2 of the noise tile edge

  // ==========================================================================
  // Quantization limits and channel phases
  // ==========================================================================
  localparam logic [2:0] QUANT_MIN = 3'h2;   // Fewest output bits
  localparam logic [2:0] QUANT_MAX = 3'h6;   // Most output bits
  localparam logic [TILE_W-1:0] PHASE_R = 5'h00;  // Red / V column phase
  localparam logic [TILE_W-1:0] PHASE_G = 5'h08;  // Green / Y column phase
  localparam logic [TILE_W-1:0] PHASE_B = 5'h10;  // Blue / U column phase

  // ==========================================================================
  // Saturation limits of the sharpening path
  // ==========================================================================
  localparam logic [WIDE_W-1:0] SAT_LOW  = 9'h000;  // Underflow floor
  localparam logic [WIDE_W-1:0] SAT_HIGH = 9'h1ff;  // Overflow ceiling

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    FILT_NONE,
    FILT_SMOOTH,
    FILT_SHARP
  } pdsf_filt_t;

  typedef struct packed {
    logic [CHAN_W-1:0]  red;        // Red / V
    logic [CHAN_W-1:0]  green;      // Green / Y, the filtered channel
    logic [CHAN_W-1:0]  blue;       // Blue / U
    logic [COORD_W-1:0] x;          // Destination column
    logic [COORD_W-1:0] y;          // Destination row
    logic               span_first; // First pixel of the window span
    logic               span_last;  // Last pixel of the window span
    logic               edge_hold;  // Edge of the other span, also bypassed
  } pdsf_pix_t;

  typedef struct packed {
    logic [QOUT_W-1:0]  red;        // Dithered, low aligned
    logic [QOUT_W-1:0]  green;
    logic [QOUT_W-1:0]  blue;
    logic [COORD_W-1:0] x;
    logic [COORD_W-1:0] y;
  } pdsf_out_t;

  // ==========================================================================
  // Noise table: ordered pattern on a 32 by 32 tile, top seven bits kept
  // ==========================================================================
  function automatic logic [NOISE_W-1:0] noise_lookup(
    input logic [TILE_W-1:0] row,
    input logic [TILE_W-1:0] col
  );
    logic [2*TILE_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < TILE_W; i++) begin
      acc[2*(TILE_W-1-i)+1] = row[i] ^ col[i];
      acc[2*(TILE_W-1-i)]   = row[i];
    end
    return acc[2*TILE_W-1 -: NOISE_W];
  endfunction

endpackage : pdsf_pkg

// [rtl/pdsf_dither.sv]
// Module: one channel of the ordered dither, purely combinational
module pdsf_dither (
  input  wire logic [pdsf_pkg::CHAN_W-1:0]  chan_in,   // Channel value
  input  wire logic [pdsf_pkg::NOISE_W-1:0] noise_in,  // Table entry
  input  wire logic [2:0]                   quant_in,  // Output bits, 2..6
  output logic      [pdsf_pkg::QOUT_W-1:0]  chan_out   // Dithered, low aligned
);

  // ==========================================================================
  // Scale, add noise, keep the top bits
  // ==========================================================================
  logic [pdsf_pkg::WIDE_W-1:0] wide;    // Input with zero appended
  logic [pdsf_pkg::WIDE_W-1:0] scaled;  // Range limited input
  logic [pdsf_pkg::WIDE_W-1:0] summed;  // Noise addition result
  logic [2:0]                  nshift;  // Noise shift, n minus 2

  // Range limit keeps every sum below 512, so nothing wraps at nine bits
  always_comb begin
    wide     = {chan_in, 1'b0};
    scaled   = wide - (wide >> quant_in);
    nshift   = quant_in - pdsf_pkg::QUANT_MIN;
    summed   = scaled + {2'b00, noise_in >> nshift};
    chan_out = pdsf_pkg::QOUT_W'(summed >> (4'd9 - {1'b0, quant_in}));
  end

endmodule // pdsf_dither

// [rtl/pdsf_top.sv]
// Module: three-pixel window, luma filters and dither stage of the scaled copy path

module pdsf_top (
  input  wire logic                 sys_clk_in,   // Core clock, 100 MHz
  input  wire logic                 nrst_in,      // Asynchronous reset, low
  input  wire pdsf_pkg::pdsf_pix_t  pix_in,       // Incoming pixel
  input  wire logic                 pix_valid_in, // Pixel offered
  output logic                      pix_ready_out,// Pixel taken if offered
  input  wire pdsf_pkg::pdsf_filt_t filt_in,      // Filter for this operation
  input  wire logic [2:0]           quant_in,     // Output bits for operation
  input  wire logic                 dith_en_in,   // Dither on, else top bits
  output pdsf_pkg::pdsf_out_t       res_out,      // Result pixel
  output logic                      res_valid_out,// Result held
  input  wire logic                 res_ready_in  // Writer accepts result
);

  // ==========================================================================
  // Window state: left neighbour and centre pixel
  // ==========================================================================
  pdsf_pkg::pdsf_pix_t left_r,   left_nxt;    // Previous pixel of span
  pdsf_pkg::pdsf_pix_t cent_r,   cent_nxt;    // Pixel waiting for output
  logic                cvld_r,   cvld_nxt;    // Centre occupied
  pdsf_pkg::pdsf_out_t res_r,    res_nxt;     // Output register
  logic                rvld_r,   rvld_nxt;    // Output occupied

  logic                fire;                  // Centre moves to output
  logic                take;                  // Input accepted
  logic [2:0]          quant_eff;             // Quantization held in range
  logic                bypass;                // Centre passes unfiltered
  logic [9:0]          sum_lr;                // Neighbour sum
  logic signed [11:0]  sharp_raw;             // Unclamped sharpen value
  logic [8:0]          sharp_sat;             // Clamped sharpen value
  logic [8:0]          smooth_w;              // Nine-bit neighbour sum
  logic [pdsf_pkg::CHAN_W-1:0] green_f;       // Filtered green

  // ==========================================================================
  // Flow control
  // ==========================================================================
  // A last pixel needs no right neighbour, so it leaves without waiting
  // for input; this lets the span drain with no flush beat
  always_comb begin
    fire          = cvld_r && (cent_r.span_last || pix_valid_in)
                    && (!rvld_r || res_ready_in);
    pix_ready_out = !cvld_r || (fire && !cent_r.span_last);
    take          = pix_valid_in && pix_ready_out;
  end

  // ==========================================================================
  // Green channel filters
  // ==========================================================================
  // Right neighbour is the pixel being accepted in the same cycle
  always_comb begin
    bypass    = cent_r.span_first || cent_r.span_last || cent_r.edge_hold;
    sum_lr    = {2'b00, left_r.green} + {2'b00, pix_in.green};
    smooth_w  = sum_lr[8:0];
    sharp_raw = $signed({2'b00, cent_r.green, 2'b00})
                - $signed({2'b00, sum_lr});
    if (sharp_raw < 0) begin
      sharp_sat = pdsf_pkg::SAT_LOW;
    end else if (sharp_raw > 12'sd511) begin
      sharp_sat = pdsf_pkg::SAT_HIGH;
    end else begin
      sharp_sat = sharp_raw[8:0];
    end
    // Only green is touched; red and blue never see a filter
    if (bypass) begin
      green_f = cent_r.green;
    end else begin
      case (filt_in)
        pdsf_pkg::FILT_SMOOTH: green_f = smooth_w[8:1];
        pdsf_pkg::FILT_SHARP:  green_f = sharp_sat[8:1];
        default:               green_f = cent_r.green;
      endcase
    end
  end

  // ==========================================================================
  // Noise lookup, one column phase per channel
  // ==========================================================================
  // Out-of-range quantization is clamped rather than left undefined
  always_comb begin
    if (quant_in < pdsf_pkg::QUANT_MIN) begin
      quant_eff = pdsf_pkg::QUANT_MIN;
    end else if (quant_in > pdsf_pkg::QUANT_MAX) begin
      quant_eff = pdsf_pkg::QUANT_MAX;
    end else begin
      quant_eff = quant_in;
    end
  end

  localparam logic [3*pdsf_pkg::TILE_W-1:0] PHASES =
    {pdsf_pkg::PHASE_B, pdsf_pkg::PHASE_G, pdsf_pkg::PHASE_R};

  logic [3*pdsf_pkg::CHAN_W-1:0] chan_bus;   // Channels, red lowest
  logic [3*pdsf_pkg::QOUT_W-1:0] dith_bus;   // Dithered channels
  logic [3*pdsf_pkg::QOUT_W-1:0] trunc_bus;  // Plain top bits
  logic [pdsf_pkg::TILE_W-1:0]   row_idx;    // Shared table row

  assign chan_bus = {cent_r.blue, green_f, cent_r.red};
  assign row_idx  = cent_r.y[pdsf_pkg::TILE_W-1:0];

  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    logic [pdsf_pkg::TILE_W-1:0]  col_idx;   // Phased column, wraps at 32
    logic [pdsf_pkg::NOISE_W-1:0] noise;     // Table entry
    logic [pdsf_pkg::CHAN_W-1:0]  chan;      // This channel

    assign chan    = chan_bus[ch*pdsf_pkg::CHAN_W +: pdsf_pkg::CHAN_W];
    // Five-bit add gives the modulo for free, so the tile repeats
    assign col_idx = cent_r.x[pdsf_pkg::TILE_W-1:0]
                     + PHASES[ch*pdsf_pkg::TILE_W +: pdsf_pkg::TILE_W];
    assign noise   = pdsf_pkg::noise_lookup(row_idx, col_idx);
    assign trunc_bus[ch*pdsf_pkg::QOUT_W +: pdsf_pkg::QOUT_W] =
      pdsf_pkg::QOUT_W'(chan >> (4'd8 - {1'b0, quant_eff}));

    pdsf_dither u_dither (
      .chan_in  (chan),
      .noise_in (noise),
      .quant_in (quant_eff),
      .chan_out (dith_bus[ch*pdsf_pkg::QOUT_W +: pdsf_pkg::QOUT_W])
    );
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    left_nxt = left_r;
    cent_nxt = cent_r;
    cvld_nxt = cvld_r;
    res_nxt  = res_r;
    rvld_nxt = rvld_r;
    // Output register empties when the writer takes it
    if (rvld_r && res_ready_in) begin
      rvld_nxt = 1'b0;
    end
    // Centre moves to output, dithered or cut to n bits
    if (fire) begin
      rvld_nxt    = 1'b1;
      res_nxt.x   = cent_r.x;
      res_nxt.y   = cent_r.y;
      res_nxt.red   = dith_en_in ? dith_bus[5:0]   : trunc_bus[5:0];
      res_nxt.green = dith_en_in ? dith_bus[11:6]  : trunc_bus[11:6];
      res_nxt.blue  = dith_en_in ? dith_bus[17:12] : trunc_bus[17:12];
      left_nxt    = cent_r;
      cvld_nxt    = 1'b0;
    end
    // New pixel becomes the centre
    if (take) begin
      cent_nxt = pix_in;
      cvld_nxt = 1'b1;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      left_r <= '0;
      cent_r <= '0;
      cvld_r <= 1'b0;
      res_r  <= '0;
      rvld_r <= 1'b0;
    end else begin
      left_r <= left_nxt;
      cent_r <= cent_nxt;
      cvld_r <= cvld_nxt;
      res_r  <= res_nxt;
      rvld_r <= rvld_nxt;
    end
  end

  assign res_out       = res_r;
  assign res_valid_out = rvld_r;

endmodule // pdsf_top

// [test/pdsf_properties.sv]
// Checker: port-level properties of the dither and span filter
module pdsf_properties (
  input wire logic                sys_clk_in,
  input wire logic                nrst_in,
  input wire pdsf_pkg::pdsf_pix_t pix_in,
  input wire logic                pix_valid_in,
  input wire logic                pix_ready_out,
  input wire logic [2:0]          quant_in,
  input wire pdsf_pkg::pdsf_out_t res_out,
  input wire logic                res_valid_out,
  input wire logic                res_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Clocking and helpers
  // ==========================================================================
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic take_last;  // Span end pixel taken
  assign take_last = pix_valid_in & pix_ready_out & pix_in.span_last;
  // ==========================================================================
  // Properties
  // ==========================================================================
  AST_RES_HOLD: assert property (res_valid_out & !res_ready_in |=>
    res_valid_out & $stable(res_out))
    else $error("result changed while stalled");
  AST_RES_DROP: assert property ($fell(res_valid_out) |-> $past(res_ready_in))
    else $error("result dropped without accept");
  AST_LAST_GAP: assert property (take_last |=> !pix_ready_out)
    else $error("input taken beside span end");
  AST_LAST_OUT: assert property (take_last |-> ##[2:40] res_valid_out)
    else $error("span end never left");
  AST_READY_BACK: assert property (!pix_ready_out |-> ##[1:40] pix_ready_out)
    else $error("input stalled too long");
  AST_RED_W: assert property (res_valid_out |-> (res_out.red >> quant_in) == 6'h00)
    else $error("red wider than quantization");
  AST_GREEN_W: assert property (res_valid_out |-> (res_out.green >> quant_in) == 6'h00)
    else $error("green wider than quantization");
  AST_BLUE_W: assert property (res_valid_out |-> (res_out.blue >> quant_in) == 6'h00)
    else $error("blue wider than quantization");
  // Main scenarios reached
  cover property (take_last);
  cover property (res_valid_out & !res_ready_in);
  cover property (pix_valid_in & !pix_ready_out);
endmodule // pdsf_properties

bind pdsf_top pdsf_properties u_prop (
  .sys_clk_in   (sys_clk_in),
  .nrst_in      (nrst_in),
  .pix_in       (pix_in),
  .pix_valid_in (pix_valid_in),
  .pix_ready_out(pix_ready_out),
  .quant_in     (quant_in),
  .res_out      (res_out),
  .res_valid_out(res_valid_out),
  .res_ready_in (res_ready_in)
);

// [test/pdsf_writer_model.sv]
// Writer model: takes results with random stalls of at most three cycles
module pdsf_writer_model (
  input  wire logic sys_clk_in,    // Core clock
  input  wire logic nrst_in,       // Reset, low
  output logic      res_ready_out  // Accept strobe toward the block
);
  timeunit 1ns;
  timeprecision 1ps;
  int         seed = 32'h3f15;  // Own random stream
  logic [1:0] stall_r;          // Low cycles in a row
  // Bounded stalls keep the bench's waits finite
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      res_ready_out <= 1'b0;
      stall_r       <= 2'h0;
    end else if (stall_r == 2'h3 || {$random(seed)} % 3 != 0) begin
      res_ready_out <= 1'b1;
      stall_r       <= 2'h0;
    end else begin
      res_ready_out <= 1'b0;
      stall_r       <= stall_r + 2'h1;
    end
  end
endmodule // pdsf_writer_model

// [test/pdsf_top_tb.sv]
// Testbench: random spans through filters and dither, results checked in order
module pdsf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 sys_clk_in, nrst_in, pix_valid_in, pix_ready_out;
  logic                 dith_en_in, res_valid_out, res_ready_in;
  logic [2:0]           quant_in;
  pdsf_pkg::pdsf_pix_t  pix_in;
  pdsf_pkg::pdsf_filt_t filt_in;
  pdsf_pkg::pdsf_out_t  res_out;
  pdsf_pkg::pdsf_out_t  exp_q[$];   // Notes of expected results
  pdsf_pkg::pdsf_pix_t  sp[8];      // Current span
  int                   failures, n_tests, cycles, seed, len;

  pdsf_top u_dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .pix_in(pix_in),
    .pix_valid_in(pix_valid_in), .pix_ready_out(pix_ready_out), .filt_in(filt_in),
    .quant_in(quant_in), .dith_en_in(dith_en_in), .res_out(res_out),
    .res_valid_out(res_valid_out), .res_ready_in(res_ready_in));
  pdsf_writer_model u_wr (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .res_ready_out(res_ready_in));

  // ==========================================================================
  // Reference arithmetic
  // ==========================================================================
  function automatic logic [5:0] dith(logic [7:0] d, logic [2:0] n, logic [6:0] z);
    logic [8:0] s;
    s = {d, 1'b0} - ({d, 1'b0} >> n) + (z >> (n - 3'h2));
    return dith_en_in ? 6'(s >> (9 - n)) : 6'(d >> (8 - n));
  endfunction
  function automatic logic [7:0] filt(logic [7:0] l, logic [7:0] c, logic [7:0] r);
    logic [8:0] s;
    int         v;
    s = l + r;
    v = 4 * int'(c) - int'(l) - int'(r);
    if (filt_in == pdsf_pkg::FILT_SMOOTH) return s[8:1];
    if (filt_in == pdsf_pkg::FILT_SHARP)
      return v < 0 ? 8'h00 : v > 511 ? 8'hff : 8'(v >> 1);
    return c;
  endfunction
  // Expected result of span pixel i, filter and dither inputs already set
  task automatic note(int i);
    pdsf_pkg::pdsf_out_t o;
    pdsf_pkg::pdsf_pix_t p;
    logic [7:0]          g;
    logic [2:0]          q;
    p = sp[i];
    // Widths above the range act as the widest one
    q = (quant_in > pdsf_pkg::QUANT_MAX) ? pdsf_pkg::QUANT_MAX : quant_in;
    g = (p.span_first | p.span_last | p.edge_hold) ? p.green
      : filt(sp[i-1].green, p.green, sp[i+1].green);
    o.red   = dith(p.red, q,
                   pdsf_pkg::noise_lookup(p.y[4:0], p.x[4:0] + pdsf_pkg::PHASE_R));
    o.green = dith(g, q,
                   pdsf_pkg::noise_lookup(p.y[4:0], p.x[4:0] + pdsf_pkg::PHASE_G));
    o.blue  = dith(p.blue, q,
                   pdsf_pkg::noise_lookup(p.y[4:0], p.x[4:0] + pdsf_pkg::PHASE_B));
    o.x     = p.x;
    o.y     = p.y;
    exp_q.push_back(o);
  endtask
  // ==========================================================================
  // Drivers, compares and closing
  // ==========================================================================
  task automatic send(pdsf_pkg::pdsf_pix_t p);
    pix_in       <= p;
    pix_valid_in <= 1'b1;
    do @(negedge sys_clk_in); while (pix_ready_out !== 1'b1);
    @(posedge sys_clk_in);
  endtask
  task automatic chk(pdsf_pkg::pdsf_out_t e);
    n_tests++;
    if (res_out !== e) begin
      failures++;
      $display("[FAIL] res_out exp %h got %h", e, res_out);
    end
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Clock, 100 MHz
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Hang guard, well above the expected few hundred cycles
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      wrap_up;
    end
  end
  // Result watcher; sampled at negedge where outputs are settled
  always @(negedge sys_clk_in) begin
    if (res_valid_out === 1'b1 && res_ready_in === 1'b1)
      chk(exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  end
  // Main sequence: every filter and quantization, saturating greens last
  initial begin
    seed = 32'h3f15;
    nrst_in = 1'b0;
    pix_valid_in = 1'b0;
    pix_in = '0;
    filt_in = pdsf_pkg::FILT_NONE;
    quant_in = 3'h4;
    dith_en_in = 1'b0;
    repeat (12) @(posedge sys_clk_in);
    chk_bit("ready in reset", 1'b1, pix_ready_out);
    chk_bit("valid in reset", 1'b0, res_valid_out);
    nrst_in <= 1'b1;
    for (int s = 0; s < 30; s++) begin
      // Operation settings change on the edge, read back one cycle later
      filt_in    <= pdsf_pkg::pdsf_filt_t'(s % 3);
      quant_in   <= (s == 29) ? 3'h7 : 3'(2 + s % 5);
      dith_en_in <= s[1];
      len = 1 + {$random(seed)} % 6;
      for (int i = 0; i < len; i++) begin
        sp[i].red        = 8'($random(seed));
        sp[i].green      = (s >= 24) ? (i[0] ? 8'h00 : 8'hff) : 8'($random(seed));
        sp[i].blue       = 8'($random(seed));
        sp[i].x          = 12'($random(seed));
        sp[i].y          = 12'($random(seed));
        sp[i].span_first = (i == 0);
        sp[i].span_last  = (i == len - 1);
        sp[i].edge_hold  = ({$random(seed)} % 5 == 0);
      end
      @(posedge sys_clk_in);
      for (int i = 0; i < len; i++) note(i);
      for (int i = 0; i < len; i++) send(sp[i]);
      pix_valid_in <= 1'b0;
      repeat (60) begin
        if (exp_q.size() == 0) break;
        @(posedge sys_clk_in);
      end
      repeat (2) @(posedge sys_clk_in);
    end
    chk_bit("all results seen", 1'b1, exp_q.size() == 0);
    wrap_up;
  end
endmodule // pdsf_top_tb
